/* inc/spm_pkg.sv */
// Purpose: Constants and types for the SPI master control slice
// Assumes: APB with 32-bit data, 12-bit byte addresses
// Notes:   Offsets are byte addresses, one word per register
// Contract
// - Receive and EEPROM-read modes stop after frame count plus one frames.
// - Frame count is sixteen bits in the low half; upper bits reserved.
// - Clearing enable stops a transfer at once, mid-frame.
// - While disabled both FIFOs are emptied.
// - Mode, frame count and divider registers ignore writes while enabled.
// - Clock-gate-safe output rises a delay after disabling.
// - Enable is bit zero, resets to zero, one enables.
// - Receive mode resends the first transmit word for the whole transfer.
// - Select lines follow the select bits only when a transfer starts.
// - Divider register rejects writes while enabled.
package spm_pkg;
	localparam logic [11:0] OFF_CTRL      = 12'h000;
	localparam logic [11:0] OFF_FRAME_CNT = 12'h004;
	localparam logic [11:0] OFF_ENABLE    = 12'h008;
	localparam logic [11:0] OFF_MW        = 12'h00C;
	localparam logic [11:0] OFF_TSEL      = 12'h010;
	localparam logic [11:0] OFF_DIV       = 12'h014;
	localparam logic [11:0] OFF_STATUS    = 12'h028;
	localparam logic [11:0] OFF_DATA      = 12'h060;
	localparam int          MODE_LSB      = 8;
	localparam int          ENABLE_BIT    = 0;
	localparam int          NSEL          = 3;
	localparam logic [15:0] FRAME_CNT_RST = 16'h0000;
	localparam logic [15:0] DIV_RST       = 16'h0000;
	localparam logic [NSEL-1:0] TSEL_RST  = 3'h0;
	localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
	localparam int          GATE_DELAY    = 16;

	typedef enum logic [1:0] {
		MODE_TXRX    = 2'h0,
		MODE_TX_ONLY = 2'h1,
		MODE_RX      = 2'h2,
		MODE_EEPROM  = 2'h3
	} spm_mode_e;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} spm_apb_req_s;
endpackage

/* logic/spm_top.sv */
// Purpose: SPI master enable, frame count, select and FIFO control slice
// Assumes: SPI mode 0, MSB first, fixed frame width
// Notes:   APB answers in the first access cycle
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module spm_top #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_rst,
	input  wire logic                  i_ce,
	input  wire spm_pkg::spm_apb_req_s i_apb,
	output logic [31:0]                o_prdata,
	output logic                       o_pready,
	output logic                       o_pslverr,
	output logic                       o_sclk,
	output logic                       o_mosi,
	input  wire logic                  i_miso,
	output logic [spm_pkg::NSEL-1:0]   o_target_select_line_n,
	output logic                       o_clock_gate_safe
);
	import spm_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	typedef enum {ST_IDLE, ST_XFER} spm_state_e;

	spm_state_e           state_reg;
	logic                 en_reg;
	spm_mode_e            mode_reg;
	logic [15:0]          frame_cnt_reg;
	logic [15:0]          div_reg;
	logic [NSEL-1:0]      tsel_reg;
	logic [WIDTH-1:0]     tx_mem [DEPTH];
	logic [WIDTH-1:0]     rx_mem [DEPTH];
	logic [AW-1:0]        tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
	logic [CW-1:0]        tx_cnt_reg, rx_cnt_reg;
	logic [WIDTH-1:0]     tx_sh_reg, rx_sh_reg, hold_reg;
	logic [15:0]          half_reg, frames_reg;
	logic [$clog2(WIDTH)-1:0] bit_reg;
	logic                 first_reg;
	logic [$clog2(GATE_DELAY+1)-1:0] gate_reg;

	logic setup, access, wr, rd, tx_push, tx_pop, rx_push, rx_pop, tick, last_bit, more;
	logic [WIDTH-1:0] next_word;

	function automatic logic hit(input logic [11:0] off);
		return i_apb.paddr == off;
	endfunction

	assign setup   = i_ce && i_apb.psel && !i_apb.penable;
	assign access  = i_ce && i_apb.psel && i_apb.penable && o_pready;
	assign wr      = access && i_apb.pwrite;
	assign rd      = access && !i_apb.pwrite;
	assign tx_push = wr && hit(OFF_DATA) && en_reg && (tx_cnt_reg != CW'(DEPTH));
	assign rx_pop  = rd && hit(OFF_DATA) && (rx_cnt_reg != '0);
	assign tick    = (half_reg == (div_reg >> 1) - 16'h0001);
	assign last_bit = (bit_reg == ($clog2(WIDTH))'(WIDTH - 1));
	// Receive modes count frames; otherwise run until the FIFO drains
	assign more    = (mode_reg == MODE_RX || mode_reg == MODE_EEPROM)
		? (frames_reg != frame_cnt_reg) : (tx_cnt_reg != '0);
	// Receive mode pops only the first word and resends it
	assign tx_pop  = i_ce && en_reg && (tx_cnt_reg != '0) && (mode_reg != MODE_RX || first_reg)
		&& ((state_reg == ST_IDLE && div_reg != DIV_RST)
		|| (state_reg == ST_XFER && tick && o_sclk && last_bit && more));
	assign next_word = tx_pop ? tx_mem[tx_rp_reg] : hold_reg;
	assign rx_push = i_ce && state_reg == ST_XFER && tick && o_sclk && last_bit
		&& mode_reg != MODE_TX_ONLY && (rx_cnt_reg != CW'(DEPTH));

	// APB slave: pready rises for one access cycle
	always_ff @(posedge i_ref_clk or posedge i_rst)
		if (i_rst)
		begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= ZERO_WORD;
		end
		else if (i_ce)
		begin
			o_pready  <= setup;
			o_pslverr <= setup && !(hit(OFF_CTRL) || hit(OFF_FRAME_CNT) || hit(OFF_ENABLE)
				|| hit(OFF_MW) || hit(OFF_TSEL) || hit(OFF_DIV) || hit(OFF_STATUS)
				|| hit(OFF_DATA));
			o_prdata  <= ZERO_WORD; // Microwire and unmapped read zero
			if (setup && !i_apb.pwrite)
				unique case (i_apb.paddr)
					OFF_CTRL:      o_prdata <= 32'(mode_reg) << MODE_LSB;
					OFF_FRAME_CNT: o_prdata <= {16'h0000, frame_cnt_reg};
					OFF_ENABLE:    o_prdata <= 32'(en_reg);
					OFF_TSEL:      o_prdata <= 32'(tsel_reg);
					OFF_DIV:       o_prdata <= {16'h0000, div_reg};
					OFF_STATUS:    o_prdata <= {16'h0000, 4'(rx_cnt_reg), 4'(tx_cnt_reg),
						7'h00, state_reg == ST_XFER};
					OFF_DATA:      o_prdata <= 32'(rx_mem[rx_rp_reg]);
					default:       o_prdata <= ZERO_WORD;
				endcase
		end

	// Configuration; locked registers drop writes while enabled
	always_ff @(posedge i_ref_clk or posedge i_rst)
		if (i_rst)
		begin
			en_reg        <= 1'b0;
			mode_reg      <= MODE_TXRX;
			frame_cnt_reg <= FRAME_CNT_RST;
			div_reg       <= DIV_RST;
			tsel_reg      <= TSEL_RST;
		end
		else if (wr)
		begin
			if (hit(OFF_ENABLE))
				en_reg <= i_apb.pwdata[ENABLE_BIT];
			if (hit(OFF_TSEL))
				tsel_reg <= i_apb.pwdata[NSEL-1:0];
			if (!en_reg)
			begin
				if (hit(OFF_CTRL))
					mode_reg <= spm_mode_e'(i_apb.pwdata[MODE_LSB +: 2]);
				if (hit(OFF_FRAME_CNT))
					frame_cnt_reg <= i_apb.pwdata[15:0];
				if (hit(OFF_DIV))
					div_reg <= {i_apb.pwdata[15:1], 1'b0}; // Kept even
			end
		end

	// Transmit FIFO
	always_ff @(posedge i_ref_clk or posedge i_rst)
		if (i_rst)
		begin
			tx_wp_reg  <= '0;
			tx_rp_reg  <= '0;
			tx_cnt_reg <= '0;
		end
		else if (i_ce)
		begin
			if (!en_reg)
			begin
				tx_wp_reg  <= '0;
				tx_rp_reg  <= '0;
				tx_cnt_reg <= '0;
			end
			else
			begin
				if (tx_push)
				begin
					tx_mem[tx_wp_reg] <= i_apb.pwdata[WIDTH-1:0];
					tx_wp_reg <= AW'((tx_wp_reg + 1'b1) % DEPTH);
				end
				if (tx_pop)
					tx_rp_reg <= AW'((tx_rp_reg + 1'b1) % DEPTH);
				tx_cnt_reg <= tx_cnt_reg + CW'(tx_push) - CW'(tx_pop);
			end
		end

	// Receive FIFO; frames arriving when full are lost
	always_ff @(posedge i_ref_clk or posedge i_rst)
		if (i_rst)
		begin
			rx_wp_reg  <= '0;
			rx_rp_reg  <= '0;
			rx_cnt_reg <= '0;
		end
		else if (i_ce)
		begin
			if (!en_reg)
			begin
				rx_wp_reg  <= '0;
				rx_rp_reg  <= '0;
				rx_cnt_reg <= '0;
			end
			else
			begin
				if (rx_push)
				begin
					// Shifter already holds all bits from the rising edges
					rx_mem[rx_wp_reg] <= rx_sh_reg;
					rx_wp_reg <= AW'((rx_wp_reg + 1'b1) % DEPTH);
				end
				if (rx_pop)
					rx_rp_reg <= AW'((rx_rp_reg + 1'b1) % DEPTH);
				rx_cnt_reg <= rx_cnt_reg + CW'(rx_push) - CW'(rx_pop);
			end
		end

	// Shift engine
	always_ff @(posedge i_ref_clk or posedge i_rst)
		if (i_rst)
		begin
			state_reg <= ST_IDLE;
			o_sclk    <= 1'b0;
			o_mosi    <= 1'b0;
			o_target_select_line_n <= '1;
			tx_sh_reg <= '0;
			rx_sh_reg <= '0;
			hold_reg  <= '0;
			half_reg  <= '0;
			bit_reg   <= '0;
			frames_reg <= '0;
			first_reg <= 1'b1;
		end
		else if (i_ce)
		begin
			if (!en_reg)
			begin
				state_reg <= ST_IDLE; // Abandon the frame in flight
				o_sclk    <= 1'b0;
				o_target_select_line_n <= '1;
				first_reg <= 1'b1;
			end
			else unique case (state_reg)
				ST_IDLE:
					if (tx_cnt_reg != '0 && div_reg != DIV_RST)
					begin
						state_reg <= ST_XFER;
						o_target_select_line_n <= ~tsel_reg; // Sampled only here
						tx_sh_reg <= next_word;
						hold_reg  <= next_word;
						o_mosi    <= next_word[WIDTH-1];
						first_reg <= 1'b0;
						half_reg  <= '0;
						bit_reg   <= '0;
						frames_reg <= '0;
					end
				ST_XFER:
				begin
					half_reg <= tick ? 16'h0000 : half_reg + 16'h0001;
					if (tick && !o_sclk)
					begin
						o_sclk    <= 1'b1;
						rx_sh_reg <= {rx_sh_reg[WIDTH-2:0], i_miso};
					end
					else if (tick)
					begin
						o_sclk <= 1'b0;
						if (!last_bit)
						begin
							bit_reg   <= bit_reg + 1'b1;
							tx_sh_reg <= tx_sh_reg << 1;
							o_mosi    <= tx_sh_reg[WIDTH-2];
						end
						else if (more)
						begin
							frames_reg <= frames_reg + 16'h0001;
							bit_reg   <= '0;
							tx_sh_reg <= next_word;
							hold_reg  <= next_word;
							o_mosi    <= next_word[WIDTH-1];
						end
						else
						begin
							state_reg <= ST_IDLE;
							o_target_select_line_n <= '1;
							// Else a later word would never drain and restart forever
							first_reg <= 1'b1;
						end
					end
				end
			endcase
		end

	// Gate-safe after the engine has stayed disabled for a while
	always_ff @(posedge i_ref_clk or posedge i_rst)
		if (i_rst)
		begin
			gate_reg          <= '0;
			o_clock_gate_safe <= 1'b0;
		end
		else if (i_ce)
		begin
			if (en_reg)
			begin
				gate_reg          <= '0;
				o_clock_gate_safe <= 1'b0;
			end
			else if (gate_reg != ($bits(gate_reg))'(GATE_DELAY))
				gate_reg <= gate_reg + 1'b1;
			else
				o_clock_gate_safe <= 1'b1;
		end

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	property p_stop_count;
		i_ce && state_reg == ST_XFER && tick && o_sclk && last_bit && mode_reg == MODE_RX
			&& frames_reg == frame_cnt_reg |=> state_reg == ST_IDLE;
	endproperty
	a_stop_count: assert property (p_stop_count) else $error("receive did not stop");
	property p_fc_read;
		setup && !i_apb.pwrite && hit(OFF_FRAME_CNT) |=> o_prdata[31:16] == 16'h0000;
	endproperty
	a_fc_read: assert property (p_fc_read) else $error("frame count upper bits set");
	property p_halt;
		i_ce && !en_reg |=> state_reg == ST_IDLE && o_target_select_line_n == '1;
	endproperty
	a_halt: assert property (p_halt) else $error("transfer active while disabled");
	property p_flush;
		!en_reg && $past(!en_reg) |-> tx_cnt_reg == '0 && rx_cnt_reg == '0;
	endproperty
	a_flush: assert property (p_flush) else $error("FIFO not emptied");
	property p_lock;
		en_reg && wr && hit(OFF_FRAME_CNT) |=> $stable(frame_cnt_reg);
	endproperty
	a_lock: assert property (p_lock) else $error("locked register changed");
	property p_gate;
		$fell(en_reg) |-> !o_clock_gate_safe ##1 (!en_reg)[*8] ##0 !o_clock_gate_safe;
	endproperty
	a_gate: assert property (p_gate) else $error("gate-safe too early");
	property p_gate_on;
		en_reg |=> !o_clock_gate_safe;
	endproperty
	a_gate_on: assert property (p_gate_on) else $error("gate-safe while enabled");
	property p_enable;
		wr && hit(OFF_ENABLE) |=> en_reg == $past(i_apb.pwdata[ENABLE_BIT]);
	endproperty
	a_enable: assert property (p_enable) else $error("enable bit not written");
	property p_resend;
		mode_reg == MODE_RX && !first_reg |-> !tx_pop;
	endproperty
	a_resend: assert property (p_resend) else $error("receive mode popped again");
	property p_sel;
		state_reg == ST_IDLE && $past(state_reg == ST_IDLE) |-> $stable(o_target_select_line_n);
	endproperty
	a_sel: assert property (p_sel) else $error("select moved outside start");
	property p_div;
		en_reg && wr && hit(OFF_DIV) |=> $stable(div_reg);
	endproperty
	a_div: assert property (p_div) else $error("divider written while enabled");
	property p_mw;
		setup && !i_apb.pwrite && hit(OFF_MW) |=> o_prdata == ZERO_WORD;
	endproperty
	a_mw: assert property (p_mw) else $error("microwire reads nonzero");
	c_rx_done: cover property (state_reg == ST_XFER && mode_reg == MODE_RX ##1 state_reg == ST_IDLE);
	c_abort: cover property (state_reg == ST_XFER ##1 !en_reg);
	c_gate: cover property ($rose(o_clock_gate_safe));
endmodule // spm_top

/* sim/spm_target_model.sv */
// Purpose: Behavioural SPI target on the far side of the master
// Assumes: Mode 0, target shifts on serial clock fall
// Notes:   Line toggles every cycle while not selected
`timescale 1ns/1ps
module spm_target_model (
	input  wire logic i_clk,
	input  wire logic i_sclk,
	input  wire logic i_sel_n,
	output logic      o_miso
);
	logic [7:0] pat_reg = 8'h96;
	logic       sclk_q  = 1'b0;
	logic       fall;
	initial o_miso = 1'b0;
	assign fall = sclk_q & ~i_sclk;
	always @(posedge i_clk)
	begin
		sclk_q <= i_sclk;
		// Released line must not look like valid data
		if (i_sel_n)
		begin
			o_miso  <= ~o_miso;
			pat_reg <= 8'h96;
		end
		else
		begin
			if (fall)
				pat_reg <= {pat_reg[6:0], pat_reg[7]};
			o_miso <= fall ? pat_reg[6] : pat_reg[7];
		end
	end
endmodule // spm_target_model

/* sim/tb.sv */
// Purpose: Self-checking bench for the SPI master control slice
// Assumes: APB answer arrives in the first access cycle, or later
// Notes:   Divider 4 keeps a frame at 32 clocks
`timescale 1ns/1ps
module tb;
	import spm_pkg::*;
	logic            clk = 1'b0;
	logic            rst = 1'b1;
	spm_apb_req_s    req = '0;
	logic [31:0]     prdata;
	logic [31:0]     q;
	logic            pready, pslverr, sclk, mosi, miso, gate, e;
	logic            chk_on = 1'b0;
	logic            ce = 1'b0;
	logic [7:0]      sh = 8'h00;
	logic [NSEL-1:0] sel_n;
	int              failures = 0;
	int              n_compared = 0;
	int              rises = 0;
	always #2 clk = ~clk;
	spm_top #(.WIDTH(8), .DEPTH(4)) i_dut (.i_ref_clk(clk), .i_rst(rst), .i_ce(ce),
		.i_apb(req), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.o_sclk(sclk), .o_mosi(mosi), .i_miso(miso), .o_target_select_line_n(sel_n),
		.o_clock_gate_safe(gate));
	spm_target_model i_tgt (.i_clk(clk), .i_sclk(sclk), .i_sel_n(&sel_n), .o_miso(miso));
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_compared++;
		if (s !== x)
		begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		// Request stands until an edge samples pready high; data taken there
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			failures++;
		q = prdata;
		e = pslverr;
		req <= '0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wait_change(input logic [NSEL-1:0] v);
		int n;
		n = 0;
		do begin @(negedge clk); n++; end while (sel_n === v && n < 2000);
		if (n >= 2000)
			failures++;
	endtask
	task automatic summarize;
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge sclk)
	begin
		rises++;
		sh = {sh[6:0], mosi};
		if (chk_on && rises % 8 == 0)
			chk(32'(sh), 32'hA5);
	end
	initial
	begin
		#40000;
		failures++;
		summarize();
	end
	initial
	begin
		cyc(8);
		rst <= 1'b0;
		// Clock enable low freezes the gate-safe delay counter
		cyc(GATE_DELAY + 4);
		chk(32'(gate), 32'h0);
		ce <= 1'b1;
		cyc(GATE_DELAY + 4);
		chk(32'(gate), 32'h1);
		rd(OFF_ENABLE, 32'h0);
		rd(OFF_TSEL, 32'h0);
		wr(OFF_FRAME_CNT, 32'hFFFF_FFFF);
		rd(OFF_FRAME_CNT, 32'h0000_FFFF);
		wr(OFF_MW, 32'hFFFF_FFFF);
		rd(OFF_MW, 32'h0);
		apb(1'b0, 12'h100, 32'h0);
		chk(32'(e), 32'h1);
		$display("test registers done");
		wr(OFF_CTRL, 32'(MODE_RX) << MODE_LSB);
		wr(OFF_FRAME_CNT, 32'h2);
		wr(OFF_DIV, 32'h4);
		wr(OFF_TSEL, 32'h1);
		wr(OFF_ENABLE, 32'h1);
		rd(OFF_ENABLE, 32'h1);
		cyc(GATE_DELAY + 4);
		chk(32'(gate), 32'h0);
		wr(OFF_FRAME_CNT, 32'h7);
		wr(OFF_DIV, 32'h8);
		rd(OFF_FRAME_CNT, 32'h2);
		rd(OFF_DIV, 32'h4);
		rises = 0;
		chk_on = 1'b1;
		wr(OFF_DATA, 32'hA5);
		wait_change(3'b111);
		chk(32'(sel_n), 32'h6);
		wait_change(3'b110);
		cyc(40);
		chk(32'(rises), 32'd24);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(32'(q[15:12]), 32'h3);
		rd(OFF_DATA, 32'h96);
		chk_on = 1'b0;
		wr(OFF_ENABLE, 32'h0);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(32'(q[15:8]), 32'h0);
		chk(32'(gate), 32'h0);
		cyc(GATE_DELAY + 4);
		chk(32'(gate), 32'h1);
		$display("test receive done");
		wr(OFF_CTRL, 32'h0);
		wr(OFF_ENABLE, 32'h1);
		wr(OFF_TSEL, 32'h2);
		cyc(4);
		chk(32'(sel_n), 32'h7);
		wr(OFF_DATA, 32'h5A);
		wr(OFF_DATA, 32'hC3);
		wait_change(3'b111);
		chk(32'(sel_n), 32'h5);
		cyc(20);
		wr(OFF_ENABLE, 32'h0);
		cyc(2);
		chk(32'(sclk), 32'h0);
		chk(32'(sel_n), 32'h7);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(32'(q[15:8]), 32'h0);
		$display("test abort done");
		summarize();
	end
endmodule // tb
